// >>> rtl/camera_io_line_timer.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "cam_io_params.svh"
module camera_io_line_timer
  import cam_io_pkg::*;
#(
  parameter int CYC_PER_US = `CYC_PER_US
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  input wire logic [`ADDR_W-1:0] i_awaddr,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  // axi4-lite write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic i_arvalid,
  input wire logic [`ADDR_W-1:0] i_araddr,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // sensor timing from the acquisition logic
  input wire logic i_frame_readout,
  input wire logic i_exposure_start,
  input wire logic i_exposure_end,
  input wire logic i_bottom_row_exp_start,
  input wire logic i_top_row_exp_end,
  input wire logic i_exp_exceeds_readout,
  // pins
  input wire logic i_external_trigger_input,
  output logic o_line_out,
  output logic o_line_oe,
  // sensor-side indications
  output logic o_exposure_active,
  output logic o_strobe_window
);
  // software settings
  src_sel_t line_sel_reg, trig_src_reg;
  act_mode_t act_reg;
  logic invert_reg, user_bit_reg, timer_restart_reg;
  logic [31:0] delay_reg, dur_reg;
  logic [`DEB_W-1:0] deb_reg;
  // bus slave state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wdata_reg;
  logic [3:0] wstrb_reg;
  logic [`ADDR_W-1:0] awaddr_reg;
  logic do_write;
  logic [31:0] wr_word;
  // line and timer state
  logic exposure_reg, strobe_reg, line_out_reg, line_oe_reg;
  logic ext_filt, trig_src_lvl, trig_prev_reg, lvl_ok, edge_hit, timer_out;
  timer_state_e tmr_state_reg;
  logic [31:0] tmr_us_reg;
  logic [7:0] tmr_cyc_reg;

  // picks one internal signal by its code; unknown codes give a low level
  function automatic logic pick_src(input src_sel_t sel, input logic frame, input logic expo,
                                    input logic user, input logic tmr, input logic ext, input logic strb);
    case (sel)
      `SRC_FRAME: pick_src = frame;
      `SRC_EXPOSURE: pick_src = expo;
      `SRC_USER: pick_src = user;
      `SRC_TIMER: pick_src = tmr;
      `SRC_EXT_TRIG: pick_src = ext;
      `SRC_STROBE: pick_src = strb;
      default: pick_src = 1'b0;
    endcase
  endfunction : pick_src

  // byte-lane merge of a write onto the current word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // true in the last cycle of a span of target microseconds, at once for zero
  function automatic logic span_done(input logic [31:0] us, input logic [7:0] cyc, input logic [31:0] target);
    span_done = (target == 32'h00000000) || ((us == target - 32'h00000001) && (cyc == 8'(CYC_PER_US - 1)));
  endfunction : span_done

  // register read view; status word shows the block's live levels
  function automatic logic [31:0] read_word(input logic [`ADDR_W-1:0] a);
    logic [31:0] w;
    w = `RST_WORD;
    case (a)
      `ADDR_LINE_CTRL: begin
        w[`LC_SEL_MSB:`LC_SEL_LSB] = line_sel_reg;
        w[`LC_INV_BIT] = invert_reg;
        w[`LC_USER_BIT] = user_bit_reg;
      end
      `ADDR_TIMER_CTRL: begin
        w[`TC_SRC_MSB:`TC_SRC_LSB] = trig_src_reg;
        w[`TC_ACT_MSB:`TC_ACT_LSB] = act_reg;
      end
      `ADDR_TIMER_DELAY: w = delay_reg;
      `ADDR_TIMER_DUR: w = dur_reg;
      `ADDR_DEBOUNCE: w[`DEB_W-1:0] = deb_reg;
      `ADDR_STATUS: w[5:0] = {i_frame_readout, exposure_reg, strobe_reg, timer_out, ext_filt, line_out_reg};
      default: w = `RST_WORD;
    endcase
    read_word = w;
  endfunction : read_word

  function automatic logic addr_ok(input logic [`ADDR_W-1:0] a);
    addr_ok = (a == `ADDR_LINE_CTRL) || (a == `ADDR_TIMER_CTRL) || (a == `ADDR_TIMER_DELAY) ||
              (a == `ADDR_TIMER_DUR) || (a == `ADDR_DEBOUNCE) || (a == `ADDR_STATUS);
  endfunction : addr_ok

  // write side: address and data taken in either order, answer once both are held
  assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_word = merge(read_word(awaddr_reg), wdata_reg, wstrb_reg);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= `RST_WORD;
      wstrb_reg <= 4'h0;
    end else begin
      if (awready_reg && i_awvalid) begin
        awready_reg <= 1'b0;
        awaddr_reg <= i_awaddr;
      end
      if (wready_reg && i_wvalid) begin
        wready_reg <= 1'b0;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (addr_ok(awaddr_reg) && awaddr_reg != `ADDR_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // setting registers; long delay and debounce times saturate at their largest legal value, the duration is kept as written
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      line_sel_reg <= `SRC_OFF;
      invert_reg <= 1'b0;
      user_bit_reg <= 1'b0;
      trig_src_reg <= `SRC_OFF;
      act_reg <= `ACT_FALL;
      delay_reg <= `RST_WORD;
      dur_reg <= `RST_WORD;
      deb_reg <= '0;
      timer_restart_reg <= 1'b0;
    end else begin
      timer_restart_reg <= 1'b0;
      if (do_write) begin
        case (awaddr_reg)
          `ADDR_LINE_CTRL: begin
            line_sel_reg <= wr_word[`LC_SEL_MSB:`LC_SEL_LSB];
            invert_reg <= wr_word[`LC_INV_BIT];
            user_bit_reg <= wr_word[`LC_USER_BIT];
          end
          `ADDR_TIMER_CTRL: begin
            trig_src_reg <= wr_word[`TC_SRC_MSB:`TC_SRC_LSB];
            act_reg <= wr_word[`TC_ACT_MSB:`TC_ACT_LSB];
            timer_restart_reg <= wr_word[`TC_RESTART_BIT];
          end
          `ADDR_TIMER_DELAY: delay_reg <= (wr_word > `DELAY_MAX_US) ? `DELAY_MAX_US : wr_word;
          `ADDR_TIMER_DUR: dur_reg <= wr_word;
          `ADDR_DEBOUNCE: deb_reg <= (wr_word > `DEBOUNCE_MAX_US) ? `DEB_W'(`DEBOUNCE_MAX_US) : wr_word[`DEB_W-1:0];
          default: deb_reg <= deb_reg;
        endcase
      end
    end
  end

  // read side: one read under way, data latched with the answer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= `RST_WORD;
      rresp_reg <= `RESP_OKAY;
    end else if (arready_reg && i_arvalid) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= read_word(i_araddr);
      rresp_reg <= addr_ok(i_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // exposure and strobe windows built from the sensor's row events
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      exposure_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      if (i_exposure_start) begin
        exposure_reg <= 1'b1;
      end else if (i_exposure_end) begin
        exposure_reg <= 1'b0;
      end
      // without the overlap there is no window in which all rows expose at once
      if (!i_exp_exceeds_readout) begin
        strobe_reg <= 1'b0;
      end else if (i_bottom_row_exp_start) begin
        strobe_reg <= 1'b1;
      end else if (i_top_row_exp_end) begin
        strobe_reg <= 1'b0;
      end
    end
  end

  // the external pin is filtered before anything uses it
  io_debounce #(.CYC_PER_US(CYC_PER_US), .TIME_W(`DEB_W)) u_debounce (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_level(i_external_trigger_input),
    .i_time_us(deb_reg),
    .o_level(ext_filt)
  );

  // timer trigger: frame, exposure, input and strobe feed it; user and timer read as a constant low
  assign trig_src_lvl = pick_src(trig_src_reg, i_frame_readout, exposure_reg, 1'b0, 1'b0, ext_filt, strobe_reg);
  assign lvl_ok = (act_reg == `ACT_HIGH) ? trig_src_lvl : !trig_src_lvl;
  assign edge_hit = (act_reg == `ACT_RISE) ? (trig_src_lvl && !trig_prev_reg) :
                    (act_reg == `ACT_FALL) ? (!trig_src_lvl && trig_prev_reg) : 1'b0;
  assign timer_out = (tmr_state_reg == T_ACTIVE);

  // timer: delay, then active for the duration (edge) or while the level holds
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tmr_state_reg <= T_IDLE;
      tmr_us_reg <= `RST_WORD;
      tmr_cyc_reg <= 8'h00;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_src_lvl;
      tmr_us_reg <= `RST_WORD;
      tmr_cyc_reg <= 8'h00;
      if (timer_restart_reg) begin
        tmr_state_reg <= (trig_src_reg == `SRC_OFF) ? T_IDLE : T_DELAY;
      end else begin
        case (tmr_state_reg)
          T_IDLE: begin
            if (trig_src_reg != `SRC_OFF && (act_reg[1] ? lvl_ok : edge_hit)) begin
              tmr_state_reg <= T_DELAY;
            end
          end
          T_DELAY: begin
            if (act_reg[1] && !lvl_ok) begin
              tmr_state_reg <= T_IDLE;
            end else if (span_done(tmr_us_reg, tmr_cyc_reg, delay_reg)) begin
              tmr_state_reg <= T_ACTIVE;
            end else if (tmr_cyc_reg == 8'(CYC_PER_US - 1)) begin
              tmr_us_reg <= tmr_us_reg + 32'h00000001;
            end else begin
              tmr_us_reg <= tmr_us_reg;
              tmr_cyc_reg <= tmr_cyc_reg + 8'h01;
            end
          end
          T_ACTIVE: begin
            if (act_reg[1]) begin
              if (!lvl_ok) begin
                tmr_state_reg <= T_IDLE;
              end
            end else if (span_done(tmr_us_reg, tmr_cyc_reg, dur_reg)) begin
              tmr_state_reg <= T_IDLE;
            end else if (tmr_cyc_reg == 8'(CYC_PER_US - 1)) begin
              tmr_us_reg <= tmr_us_reg + 32'h00000001;
            end else begin
              tmr_us_reg <= tmr_us_reg;
              tmr_cyc_reg <= tmr_cyc_reg + 8'h01;
            end
          end
          default: tmr_state_reg <= T_IDLE;
        endcase
      end
    end
  end

  // line output: select, then invert last; off releases the pin
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      line_out_reg <= 1'b0;
      line_oe_reg <= 1'b0;
    end else if (line_sel_reg == `SRC_OFF || line_sel_reg == `SRC_EXT_TRIG) begin
      line_out_reg <= 1'b0;
      line_oe_reg <= 1'b0;
    end else begin
      line_out_reg <= pick_src(line_sel_reg, i_frame_readout, exposure_reg, user_bit_reg, timer_out,
                               1'b0, strobe_reg) ^ invert_reg;
      line_oe_reg <= 1'b1;
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_line_out = line_out_reg;
  assign o_line_oe = line_oe_reg;
  assign o_exposure_active = exposure_reg;
  assign o_strobe_window = strobe_reg;

  a_line_off_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (line_sel_reg == `SRC_OFF) |=> (!o_line_oe && !o_line_out))
    else $error("line driven while source is off");
  a_user_bit_line: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (line_sel_reg == `SRC_USER && !invert_reg) |=> (o_line_out == $past(user_bit_reg)))
    else $error("line does not follow user bit");
  a_invert_frame: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (line_sel_reg == `SRC_FRAME && invert_reg) |=> (o_line_out == !$past(i_frame_readout)))
    else $error("inverted frame line wrong");
  a_exposure_window: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_exposure_end && !i_exposure_start) |=> !o_exposure_active)
    else $error("exposure signal did not fall at end");
  a_strobe_gated: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_exp_exceeds_readout |=> !o_strobe_window)
    else $error("strobe without exposure overlap");
  a_edge_duration: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (tmr_state_reg == T_ACTIVE && !act_reg[1] && dur_reg != 32'h00000000) |-> (tmr_us_reg < dur_reg))
    else $error("edge timer overran its duration");
  a_delay_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(tmr_state_reg == T_ACTIVE) |-> ($past(tmr_state_reg) == T_DELAY))
    else $error("timer active without delay");
  a_restart_delay: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (timer_restart_reg && trig_src_reg != `SRC_OFF) |=> (tmr_state_reg == T_DELAY))
    else $error("restart did not restart delay");
  a_rise_trigger: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (tmr_state_reg == T_IDLE && !timer_restart_reg && trig_src_reg != `SRC_OFF && act_reg == `ACT_RISE &&
     trig_src_lvl && !trig_prev_reg) |=> (tmr_state_reg == T_DELAY))
    else $error("rising edge did not start timer");
  a_level_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (tmr_state_reg == T_ACTIVE && act_reg[1] && !lvl_ok && !timer_restart_reg) |=> (tmr_state_reg == T_IDLE))
    else $error("level timer held after source left level");
endmodule : camera_io_line_timer
`default_nettype wire

// >>> rtl/cam_io_params.svh
`ifndef CAM_IO_PARAMS_SVH
`define CAM_IO_PARAMS_SVH
// register byte addresses on the AXI4-Lite slave
`define ADDR_W 6
`define ADDR_LINE_CTRL 6'h00
`define ADDR_TIMER_CTRL 6'h04
`define ADDR_TIMER_DELAY 6'h08
`define ADDR_TIMER_DUR 6'h0C
`define ADDR_DEBOUNCE 6'h10
`define ADDR_STATUS 6'h14
// field positions
`define LC_SEL_MSB 4
`define LC_SEL_LSB 0
`define LC_INV_BIT 8
`define LC_USER_BIT 16
`define TC_SRC_MSB 4
`define TC_SRC_LSB 0
`define TC_ACT_MSB 9
`define TC_ACT_LSB 8
`define TC_RESTART_BIT 16
// source codes shared by the line selector and the timer trigger selector
`define SRC_OFF 5'h00
`define SRC_FRAME 5'h04
`define SRC_EXPOSURE 5'h06
`define SRC_USER 5'h0A
`define SRC_TIMER 5'h12
`define SRC_EXT_TRIG 5'h16
`define SRC_STROBE 5'h1E
// timer activation codes
`define ACT_FALL 2'h0
`define ACT_RISE 2'h1
`define ACT_LOW 2'h2
`define ACT_HIGH 2'h3
// time base
`define CLK_PERIOD_NS 20
`define US_IN_NS 1000
`define CYC_PER_US ((`US_IN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_MAX_US 32'h000F4240
`define DELAY_MAX_US 32'h03938700
`define DEB_W 20
// bus answers and reset values
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_WORD 32'h00000000
`endif

// >>> rtl/cam_io_pkg.sv
package cam_io_pkg;
  typedef enum logic [1:0] {T_IDLE, T_DELAY, T_ACTIVE} timer_state_e;
  typedef logic [4:0] src_sel_t;
  typedef logic [1:0] act_mode_t;
endpackage : cam_io_pkg

// >>> rtl/io_debounce.sv
`timescale 1ns/10ps
`default_nettype none
`include "cam_io_params.svh"
module io_debounce #(
  parameter int CYC_PER_US = `CYC_PER_US,
  parameter int TIME_W = `DEB_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // raw pin and programmed time
  input wire logic i_level,
  input wire logic [TIME_W-1:0] i_time_us,
  // filtered level
  output logic o_level
);
  logic s1_reg, s2_reg, s3_reg, agreed_reg, filt_reg;
  logic [7:0] cyc_reg;
  logic [TIME_W-1:0] us_reg;
  logic expired;

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      agreed_reg <= 1'b0;
    end else begin
      s1_reg <= i_level;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        agreed_reg <= s3_reg;
      end
    end
  end

  // the new level must have stood for the whole programmed time
  assign expired = (i_time_us == '0) ||
                   ((us_reg == i_time_us - 1'b1) && (cyc_reg == 8'(CYC_PER_US - 1)));

  // a pulse shorter than the time clears the count and leaves the output alone
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      filt_reg <= 1'b0;
      cyc_reg <= 8'h00;
      us_reg <= '0;
    end else if (agreed_reg == filt_reg) begin
      cyc_reg <= 8'h00;
      us_reg <= '0;
    end else if (expired) begin
      filt_reg <= agreed_reg;
      cyc_reg <= 8'h00;
      us_reg <= '0;
    end else if (cyc_reg == 8'(CYC_PER_US - 1)) begin
      cyc_reg <= 8'h00; // microsecond resolution of the programmed time
      us_reg <= us_reg + 1'b1;
    end else begin
      cyc_reg <= cyc_reg + 8'h01;
    end
  end

  assign o_level = filt_reg;

  a_deb_hold_short: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (agreed_reg != filt_reg && !expired) |=> (filt_reg == $past(filt_reg)))
    else $error("filtered level changed before debounce time");
  a_deb_take_level: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (agreed_reg != filt_reg && expired) |=> (filt_reg == $past(agreed_reg)))
    else $error("stable level not taken after debounce time");
endmodule : io_debounce
`default_nettype wire

// >>> testbench/flash_gear_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_gear_model (
  // clock
  input wire logic i_clk_sys,
  // line from the camera
  input wire logic i_line_out,
  input wire logic i_line_oe,
  // trigger pin and level seen on the line
  output logic o_trig_pin,
  output logic o_line_seen
);
  // an undriven line rests low through the lamp's pull-down
  assign o_line_seen = i_line_oe ? i_line_out : 1'h0;
  initial o_trig_pin = 1'h0;
  // hold the pin for n clocks; called just after an edge
  task automatic fire(input int n);
    o_trig_pin <= 1'h1;
    repeat (n) @(posedge i_clk_sys);
    o_trig_pin <= 1'h0;
  endtask : fire
endmodule : flash_gear_model
`default_nettype wire

// >>> testbench/camera_io_line_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "cam_io_params.svh"
module camera_io_line_timer_bench;
  localparam int CYC = 2;
  localparam int DLY = 3;
  localparam int DUR = 2;
  logic i_clk_sys = 1'h0;
  logic i_rst = 1'h1;
  // response readies stay high, so each answer is taken at the edge it is seen
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h1, i_arvalid = 1'h0, i_rready = 1'h1;
  logic [`ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = '0;
  logic [3:0] i_wstrb = 4'hF;
  logic i_frame_readout = 1'h0, i_exposure_start = 1'h0, i_exposure_end = 1'h0;
  logic i_bottom_row_exp_start = 1'h0, i_top_row_exp_end = 1'h0, i_exp_exceeds_readout = 1'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_line_out, o_line_oe;
  logic o_exposure_active, o_strobe_window, trig_pin, line_seen;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic [31:0] o_rdata, rd;
  int fails = 0, n_tests = 0, lat, cnt;
  // 50 MHz system clock
  always #10 i_clk_sys = ~i_clk_sys;
  camera_io_line_timer #(.CYC_PER_US(CYC)) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .o_awready(o_awready), .i_wvalid(i_wvalid),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr), .o_arready(o_arready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp), .i_rready(i_rready),
    .i_frame_readout(i_frame_readout), .i_exposure_start(i_exposure_start), .i_exposure_end(i_exposure_end),
    .i_bottom_row_exp_start(i_bottom_row_exp_start), .i_top_row_exp_end(i_top_row_exp_end),
    .i_exp_exceeds_readout(i_exp_exceeds_readout), .i_external_trigger_input(trig_pin),
    .o_line_out(o_line_out), .o_line_oe(o_line_oe), .o_exposure_active(o_exposure_active),
    .o_strobe_window(o_strobe_window));
  flash_gear_model u_gear (.i_clk_sys(i_clk_sys), .i_line_out(o_line_out), .i_line_oe(o_line_oe),
    .o_trig_pin(trig_pin), .o_line_seen(line_seen));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    i_awvalid <= 1'h1;
    i_awaddr <= a;
    i_wvalid <= 1'h1;
    i_wdata <= d;
    for (k = 0; k < 40; k++) begin
      @(posedge i_clk_sys);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
      if (o_bvalid) break;
    end
    chk(o_bresp, er);
    if (k == 40) begin
      fails++;
      stop_test();
    end
  endtask : wr
  task automatic rdr(input logic [`ADDR_W-1:0] a);
    int k;
    i_arvalid <= 1'h1;
    i_araddr <= a;
    for (k = 0; k < 40; k++) begin
      @(posedge i_clk_sys);
      if (o_arready) i_arvalid <= 1'h0;
      if (o_rvalid) break;
    end
    rd = o_rdata;
    rsp = o_rresp;
    if (k == 40) begin
      fails++;
      stop_test();
    end
  endtask : rdr
  // counts high cycles on the line and the first one
  task automatic watch();
    lat = 0;
    cnt = 0;
    for (int i = 1; i <= 40; i++) begin
      tick(1);
      if (line_seen === 1'h1) begin
        cnt++;
        if (lat == 0) lat = i;
      end
    end
  endtask : watch
  task automatic t_regs();
    chk(o_line_oe, 1'h0);
    chk({o_awready, o_wready, o_arready, o_bvalid, o_rvalid}, 5'h1C);
    rdr(`ADDR_LINE_CTRL);
    chk(rd, `RST_WORD);
    rdr(6'h18);
    chk(rsp, `RESP_SLVERR);
    wr(`ADDR_STATUS, 32'h0000003F, `RESP_SLVERR);
    wr(`ADDR_DEBOUNCE, 32'h000FFFFF, `RESP_OKAY);
    rdr(`ADDR_DEBOUNCE);
    chk(rd, `DEBOUNCE_MAX_US);
    $display("regs done");
  endtask : t_regs
  task automatic t_lines();
    for (int v = 0; v < 4; v++) begin
      wr(`ADDR_LINE_CTRL, {15'h0, v[1], 7'h0, v[0], 3'h0, `SRC_USER}, `RESP_OKAY);
      tick(2);
      chk({o_line_oe, line_seen}, {1'h1, v[1] ^ v[0]});
    end
    wr(`ADDR_LINE_CTRL, 32'h00010000, `RESP_OKAY);
    tick(2);
    chk(o_line_oe, 1'h0);
    wr(`ADDR_LINE_CTRL, 32'h00000104, `RESP_OKAY);
    tick(2);
    chk(line_seen, 1'h1);
    i_frame_readout <= 1'h1;
    tick(3);
    chk(line_seen, 1'h0);
    i_frame_readout <= 1'h0;
    wr(`ADDR_LINE_CTRL, 32'h00000006, `RESP_OKAY);
    i_exposure_start <= 1'h1;
    tick(1);
    i_exposure_start <= 1'h0;
    tick(2);
    chk({o_exposure_active, line_seen}, 2'h3);
    i_exposure_end <= 1'h1;
    tick(1);
    i_exposure_end <= 1'h0;
    tick(2);
    chk({o_exposure_active, line_seen}, 2'h0);
    wr(`ADDR_LINE_CTRL, 32'h0000001E, `RESP_OKAY);
    for (int s = 0; s < 3; s++) begin
      i_exp_exceeds_readout <= (s != 2);
      i_bottom_row_exp_start <= (s != 1);
      i_top_row_exp_end <= (s == 1);
      tick(1);
      i_bottom_row_exp_start <= 1'h0;
      i_top_row_exp_end <= 1'h0;
      tick(2);
      chk({o_strobe_window, line_seen}, (s == 0) ? 2'h3 : 2'h0);
    end
    $display("lines done");
  endtask : t_lines
  task automatic t_timer();
    wr(`ADDR_LINE_CTRL, 32'h00000012, `RESP_OKAY);
    wr(`ADDR_TIMER_DELAY, DLY, `RESP_OKAY);
    wr(`ADDR_TIMER_DUR, DUR, `RESP_OKAY);
    for (int a = 1; a >= 0; a--) begin
      wr(`ADDR_TIMER_CTRL, {22'h0, a[1:0], 3'h0, `SRC_FRAME}, `RESP_OKAY);
      i_frame_readout <= a[0];
      watch();
      chk(cnt, DUR * CYC);
      chk(lat >= DLY * CYC + 3 && lat <= DLY * CYC + 6, 1'h1);
    end
    wr(`ADDR_TIMER_CTRL, 32'h00010104, `RESP_OKAY);
    watch();
    chk(cnt, DUR * CYC);
    wr(`ADDR_TIMER_CTRL, 32'h00000304, `RESP_OKAY);
    i_frame_readout <= 1'h1;
    watch();
    chk(cnt, 41 - lat);
    i_frame_readout <= 1'h0;
    tick(4);
    chk(line_seen, 1'h0);
    $display("timer done");
  endtask : t_timer
  task automatic t_debounce();
    wr(`ADDR_DEBOUNCE, 32'h00000003, `RESP_OKAY);
    wr(`ADDR_TIMER_CTRL, 32'h00000116, `RESP_OKAY);
    fork u_gear.fire(4); join_none
    watch();
    chk(cnt, 0);
    fork u_gear.fire(60); join_none
    tick(4);
    rdr(`ADDR_STATUS);
    chk(rd[1], 1'h0);
    watch();
    chk(cnt, DUR * CYC);
    tick(30);
    rdr(`ADDR_STATUS);
    chk(rd[1], 1'h0);
    $display("debounce done");
  endtask : t_debounce
  // reset for eight clocks, then the scenarios in turn
  initial begin
    tick(8);
    i_rst <= 1'h0;
    tick(1);
    t_regs();
    t_lines();
    t_timer();
    t_debounce();
    stop_test();
  end
endmodule : camera_io_line_timer_bench
`default_nettype wire
